// [rtl/ddrms_defines.vh]
// constants for the registered ddr module mode and burst setup block
`ifndef DDRMS_DEFINES_VH
`define DDRMS_DEFINES_VH
// ==========================================
// mode word field positions
`define DDRMS_BL_LSB 0
`define DDRMS_BL_MSB 2
`define DDRMS_BT_BIT 3
`define DDRMS_CL_LSB 4
`define DDRMS_CL_MSB 6
`define DDRMS_OP_LSB 7
`define DDRMS_OP_MSB 12
`define DDRMS_DLLRST_BIT 8
`define DDRMS_MODE_RESET 13'h0000
// ==========================================
// burst length and latency codes
`define DDRMS_BL_CODE_2 3'h1
`define DDRMS_BL_CODE_4 3'h2
`define DDRMS_BL_CODE_8 3'h3
`define DDRMS_CL_CODE_2 3'h2
`define DDRMS_CL_CODE_25 3'h6
// whole clocks of read latency at either setting, the half is flagged
`define DDRMS_CL_CYCLES 2'h2
// ==========================================
// command encoding {cs_n, ras_n, cas_n, we_n}
`define DDRMS_CMD_MRS 4'h0
`define DDRMS_CMD_READ 4'h5
`define DDRMS_CMD_WRITE 4'h4
// ==========================================
// module info store and its serial slave address
`define DDRMS_STORE_DEPTH 256
`define DDRMS_STORE_AW 8
`define DDRMS_DEV_TYPE 4'ha
`endif

// [rtl/ddrms_store.v]
// 256 x 8 module info store with registered read data
`include "ddrms_defines.vh"
module ddrms_store #(
  parameter DEPTH = `DDRMS_STORE_DEPTH,
  parameter AW = `DDRMS_STORE_AW
) (
  input wire clk,
  input wire wr_en,
  input wire [AW-1:0] wr_addr,
  input wire [7:0] wr_data,
  input wire [AW-1:0] rd_addr,
  output reg [7:0] rd_data_reg
);
  reg [7:0] mem [0:DEPTH-1];

  // ==========================================
  // single write port, read port registered
  always @(posedge clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data_reg <= mem[rd_addr];
  end
endmodule

// [rtl/ddrms_top.v]
// registered command stage, mode word, burst sequencer and info store slave
// Notes on behaviour
// - command and address are captured, then reach the chips one clock later
// - info store holds 256 bytes; low half module data, high half free
// - info store is read and written by i2c; straps pick one of eight addresses
// - write protect is held off, so store writes are never refused
// - mode word holds until rewritten; the dll reset bit clears itself
// - a mode load never touches stored memory contents
// - bits 0-2 length, 3 type, 4-6 latency, 7-12 operating mode
// - lengths 2, 4, 8 for both types, same for reads and writes
// - programmed length bounds columns moved per read or write
// - burst stays in aligned length-sized block, wraps at its edge
// - top block bit is 9 on small module, 9 and 11 on large
// - burst type comes from mode bit 3
// - sequential counts up modulo length; interleaved is start xor count
// - read latency 2 or 2.5 clocks after the read reaches the chips
// - bit 8 alone set in bits 7-12 starts a dll reset
`include "ddrms_defines.vh"
module ddrms_top #(
  parameter LARGE_MODULE = 0
) (
  input wire clk,
  input wire rst,
  input wire cs_n,
  input wire ras_n,
  input wire cas_n,
  input wire we_n,
  input wire [1:0] ba,
  input wire [12:0] addr,
  output reg chip_cs_n_reg,
  output reg chip_ras_n_reg,
  output reg chip_cas_n_reg,
  output reg chip_we_n_reg,
  output reg [1:0] chip_ba_reg,
  output reg [12:0] chip_addr_reg,
  output reg [12:0] operating_mode_word_reg,
  output reg dll_reset_pulse_reg,
  output reg burst_active_reg,
  output reg burst_is_read_reg,
  output reg [10:0] burst_col_reg,
  output reg read_first_data_reg,
  output reg read_half_late_reg,
  input wire [2:0] strap_address_select,
  input wire scl_i,
  input wire sda_i,
  output wire sda_o,
  output reg sda_oe_n_reg
);
  // ==========================================
  // decode helpers
  function [3:0] len_of;
    input [2:0] code;
    begin
      case (code)
        `DDRMS_BL_CODE_2: len_of = 4'h2;
        `DDRMS_BL_CODE_4: len_of = 4'h4;
        `DDRMS_BL_CODE_8: len_of = 4'h8;
        default: len_of = 4'h0; // reserved code, no burst at all
      endcase
    end
  endfunction

  function [10:0] col_of;
    input [12:0] a;
    begin
      // large module adds a11 above a9 as the top column bit
      col_of = {(LARGE_MODULE != 0) ? a[11] : 1'b0, a[9:0]};
    end
  endfunction
  wire [3:0] cmd_chip = {chip_cs_n_reg, chip_ras_n_reg, chip_cas_n_reg, chip_we_n_reg};
  // ==========================================
  // one clock register stage toward the chips
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      {chip_cs_n_reg, chip_ras_n_reg, chip_cas_n_reg, chip_we_n_reg} <= 4'hf;
      chip_ba_reg <= 2'h0;
      chip_addr_reg <= 13'h0000;
    end else begin
      {chip_cs_n_reg, chip_ras_n_reg, chip_cas_n_reg, chip_we_n_reg} <=
        {cs_n, ras_n, cas_n, we_n};
      chip_ba_reg <= ba;
      chip_addr_reg <= addr;
    end
  end
  // ==========================================
  // mode word load as the command reaches the chips; no array state is touched
  wire mode_load = (cmd_chip == `DDRMS_CMD_MRS) && (chip_ba_reg == 2'h0);
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      operating_mode_word_reg <= `DDRMS_MODE_RESET;
      dll_reset_pulse_reg <= 1'b0;
    end else if (mode_load) begin
      operating_mode_word_reg <= chip_addr_reg;
      // only the exact dll reset pattern in bits 7-12 fires the pulse
      dll_reset_pulse_reg <= (chip_addr_reg[`DDRMS_OP_MSB:`DDRMS_OP_LSB] == 6'h02);
    end else begin
      // self clearing bit drops the cycle after use, the rest holds
      operating_mode_word_reg[`DDRMS_DLLRST_BIT] <= 1'b0;
      dll_reset_pulse_reg <= 1'b0;
    end
  end
  wire [2:0] bl_code = operating_mode_word_reg[`DDRMS_BL_MSB:`DDRMS_BL_LSB];
  wire burst_order_bit = operating_mode_word_reg[`DDRMS_BT_BIT];
  wire [2:0] read_latency_setting = operating_mode_word_reg[`DDRMS_CL_MSB:`DDRMS_CL_LSB];
  wire [3:0] bl_len = len_of(bl_code);
  wire [2:0] bl_mask = bl_len[2:0] - 3'h1;
  // ==========================================
  // burst column sequencer, one location per clock
  reg [10:0] base_reg;
  reg [2:0] start_reg, cnt_reg, mask_reg;
  reg order_reg;
  wire is_read = (cmd_chip == `DDRMS_CMD_READ);
  wire is_rw = is_read || (cmd_chip == `DDRMS_CMD_WRITE);
  wire [10:0] new_col = col_of(chip_addr_reg);
  wire [2:0] next_cnt = cnt_reg + 3'h1;
  wire [2:0] seq_off = (start_reg + next_cnt) & mask_reg;
  wire [2:0] ilv_off = (start_reg ^ next_cnt) & mask_reg;
  wire [2:0] off_next = order_reg ? ilv_off : seq_off;
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      burst_active_reg <= 1'b0;
      burst_is_read_reg <= 1'b0;
      burst_col_reg <= 11'h000;
      base_reg <= 11'h000;
      start_reg <= 3'h0;
      cnt_reg <= 3'h0;
      mask_reg <= 3'h0;
      order_reg <= 1'b0;
    end else if (is_rw && (bl_len != 4'h0)) begin
      // new command cuts any running burst short
      burst_active_reg <= 1'b1;
      burst_is_read_reg <= is_read;
      base_reg <= new_col & ~{8'h00, bl_mask};
      start_reg <= new_col[2:0] & bl_mask;
      mask_reg <= bl_mask;
      order_reg <= burst_order_bit;
      cnt_reg <= 3'h0;
      burst_col_reg <= new_col;
    end else if (burst_active_reg) begin
      if (next_cnt == mask_reg + 3'h1 || mask_reg == 3'h7 && next_cnt == 3'h0) begin
        burst_active_reg <= 1'b0;
      end else begin
        cnt_reg <= next_cnt;
        burst_col_reg <= base_reg | {8'h00, off_next};
      end
    end
  end
  // ==========================================
  // read latency: whole clocks counted, the half clock shown as a level
  reg [1:0] lat_cnt_reg;
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      lat_cnt_reg <= 2'h0;
      read_first_data_reg <= 1'b0;
      read_half_late_reg <= 1'b0;
    end else begin
      read_half_late_reg <= (read_latency_setting == `DDRMS_CL_CODE_25);
      read_first_data_reg <= (lat_cnt_reg == 2'h1);
      if (is_read && (read_latency_setting == `DDRMS_CL_CODE_2 ||
          read_latency_setting == `DDRMS_CL_CODE_25)) begin
        lat_cnt_reg <= `DDRMS_CL_CYCLES;
      end else if (lat_cnt_reg != 2'h0) begin
        lat_cnt_reg <= lat_cnt_reg - 2'h1;
      end
    end
  end
  // ==========================================
  // serial pins: three flops, a change counts once stages two and three agree
  reg [2:0] scl_sync_reg, sda_sync_reg;
  reg scl_reg, sda_reg, scl_q_reg, sda_q_reg;
  // delayed copies start at the idle level, so reset shows no false edge
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      scl_sync_reg <= 3'h7;
      sda_sync_reg <= 3'h7;
      scl_reg <= 1'b1;
      sda_reg <= 1'b1;
      scl_q_reg <= 1'b1;
      sda_q_reg <= 1'b1;
    end else begin
      scl_sync_reg <= {scl_sync_reg[1:0], scl_i};
      sda_sync_reg <= {sda_sync_reg[1:0], sda_i};
      scl_reg <= (scl_sync_reg[1] == scl_sync_reg[2]) ? scl_sync_reg[2] : scl_reg;
      sda_reg <= (sda_sync_reg[1] == sda_sync_reg[2]) ? sda_sync_reg[2] : sda_reg;
      scl_q_reg <= scl_reg;
      sda_q_reg <= sda_reg;
    end
  end
  wire scl_rise = scl_reg && !scl_q_reg;
  wire scl_fall = !scl_reg && scl_q_reg;
  wire bus_start = scl_reg && scl_q_reg && !sda_reg && sda_q_reg;
  wire bus_stop = scl_reg && scl_q_reg && sda_reg && !sda_q_reg;
  // ==========================================
  // serial slave for the module info store
  localparam ST_IDLE = 3'h0;
  localparam ST_DEV = 3'h1;
  localparam ST_PTR = 3'h2;
  localparam ST_WDATA = 3'h3;
  localparam ST_RDATA = 3'h4;
  reg [2:0] state_reg;
  reg [3:0] bit_reg;
  reg [7:0] shift_reg;
  reg [7:0] tx_reg;
  reg [7:0] ptr_reg;
  reg st_wr_reg;
  wire [7:0] st_rdata;
  // write protect pin is tied inactive, so the refusal term never blocks a write
  wire write_protect = 1'b0;
  assign sda_o = 1'b0; // open drain: only ever pulls low
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      state_reg <= ST_IDLE;
      bit_reg <= 4'h0;
      shift_reg <= 8'h00;
      tx_reg <= 8'hff;
      ptr_reg <= 8'h00;
      st_wr_reg <= 1'b0;
      sda_oe_n_reg <= 1'b1;
    end else begin
      st_wr_reg <= 1'b0;
      if (bus_stop) begin
        state_reg <= ST_IDLE;
        sda_oe_n_reg <= 1'b1;
      end else if (bus_start) begin
        state_reg <= ST_DEV;
        bit_reg <= 4'h0;
        sda_oe_n_reg <= 1'b1;
      end else if (scl_rise) begin
        if (bit_reg < 4'h8) begin
          shift_reg <= {shift_reg[6:0], sda_reg};
        end else if (state_reg == ST_RDATA && sda_reg) begin
          state_reg <= ST_IDLE; // master nack ends the read
        end
        bit_reg <= (bit_reg < 4'h9) ? bit_reg + 4'h1 : bit_reg;
      end else if (scl_fall && state_reg != ST_IDLE) begin
        if (bit_reg == 4'h8) begin
          sda_oe_n_reg <= 1'b1;
          case (state_reg)
            ST_DEV: begin
              if (shift_reg[7:1] == {`DDRMS_DEV_TYPE, strap_address_select}) begin
                sda_oe_n_reg <= 1'b0;
                state_reg <= shift_reg[0] ? ST_RDATA : ST_PTR;
              end else begin
                state_reg <= ST_IDLE;
              end
            end
            ST_PTR: begin
              ptr_reg <= shift_reg;
              sda_oe_n_reg <= 1'b0;
              state_reg <= ST_WDATA;
            end
            ST_WDATA: begin
              st_wr_reg <= !write_protect;
              sda_oe_n_reg <= 1'b0;
            end
            ST_RDATA: begin
              ptr_reg <= ptr_reg + 8'h01;
            end
            default: begin
              state_reg <= ST_IDLE;
            end
          endcase
        end else if (bit_reg == 4'h9) begin
          bit_reg <= 4'h0;
          // a read byte drives its msb as the acknowledge slot closes
          sda_oe_n_reg <= (state_reg == ST_RDATA) ? st_rdata[7] : 1'b1;
          tx_reg <= {st_rdata[6:0], 1'b1};
        end else if (state_reg == ST_RDATA) begin
          sda_oe_n_reg <= tx_reg[7];
          tx_reg <= {tx_reg[6:0], 1'b1};
        end
      end
      if (st_wr_reg) begin
        ptr_reg <= ptr_reg + 8'h01; // pointer advances after each stored byte
      end
    end
  end
  // 256 byte store; upper half simply more free bytes to this logic
  ddrms_store #(.DEPTH(`DDRMS_STORE_DEPTH), .AW(`DDRMS_STORE_AW)) u_store (
    .clk(clk),
    .wr_en(st_wr_reg),
    .wr_addr(ptr_reg),
    .wr_data(shift_reg),
    .rd_addr(ptr_reg),
    .rd_data_reg(st_rdata)
  );
endmodule

// [test/ddrms_i2c_host.sv]
// serial host model for the module info store, with the data wire pull-up
module ddrms_i2c_host (
  input wire clk,
  input wire sda_oe_n,
  output logic scl,
  output wire sda
);
  timeunit 1ns;
  timeprecision 1ps;
  logic sda_drv = 1'b1;
  initial scl = 1'b1;
  // pulled-up wire: low when either side pulls, so a release never shows old data
  assign sda = sda_drv & sda_oe_n;
  // a third of the serial data bit, counted on falling edges like all stimulus
  task automatic half();
    repeat (20) @(negedge clk);
  endtask
  // start or repeated start: data falls while clock is high
  task automatic start();
    half();
    sda_drv = 1'b1;
    half();
    scl = 1'b1;
    half();
    sda_drv = 1'b0;
    half();
    scl = 1'b0;
  endtask
  task automatic stop();
    half();
    sda_drv = 1'b0;
    half();
    scl = 1'b1;
    half();
    sda_drv = 1'b1;
    half();
  endtask
  // data only moves while clock is low, read back in the high phase
  task automatic bit_io(input logic b, output logic r);
    half();
    sda_drv = b;
    half();
    scl = 1'b1;
    half();
    r = sda;
    scl = 1'b0;
  endtask
  // eight bits msb first, then the acknowledge bit
  task automatic xfer(input logic [7:0] tx, input logic ack_in, output logic [7:0] rx,
    output logic ack);
    for (int i = 7; i >= 0; i--) begin
      bit_io(tx[i], rx[i]);
    end
    bit_io(ack_in, ack);
  endtask
endmodule

// [test/ddrms_top_properties.sv]
// concurrent checks on the ports of the mode and burst setup block
`include "ddrms_defines.vh"
module ddrms_top_properties #(
  parameter LARGE_MODULE = 0
) (
  input wire clk,
  input wire rst,
  input wire cs_n,
  input wire ras_n,
  input wire cas_n,
  input wire we_n,
  input wire [1:0] ba,
  input wire [12:0] addr,
  input wire chip_cs_n_reg,
  input wire chip_ras_n_reg,
  input wire chip_cas_n_reg,
  input wire chip_we_n_reg,
  input wire [1:0] chip_ba_reg,
  input wire [12:0] chip_addr_reg,
  input wire [12:0] operating_mode_word_reg,
  input wire dll_reset_pulse_reg,
  input wire burst_active_reg,
  input wire burst_is_read_reg,
  input wire [10:0] burst_col_reg,
  input wire read_first_data_reg,
  input wire read_half_late_reg
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  // ==============================
  // commands as the chips see them
  wire [3:0] cc = {chip_cs_n_reg, chip_ras_n_reg, chip_cas_n_reg, chip_we_n_reg};
  wire [2:0] bl = operating_mode_word_reg[2:0];
  wire bl_ok = bl == `DDRMS_BL_CODE_2 || bl == `DDRMS_BL_CODE_4 || bl == `DDRMS_BL_CODE_8;
  wire rd = cc == `DDRMS_CMD_READ;
  wire rw_hit = (rd || cc == `DDRMS_CMD_WRITE) && bl_ok;
  wire mrs_hit = cc == `DDRMS_CMD_MRS && chip_ba_reg == 2'h0;
  wire dll_hit = mrs_hit && chip_addr_reg[12:7] == 6'h02;
  wire slow = operating_mode_word_reg[6:4] == `DDRMS_CL_CODE_25;
  wire cl_ok = slow || operating_mode_word_reg[6:4] == `DDRMS_CL_CODE_2;
  // the small module has no top column bit, so it reads as zero
  wire [10:0] start_col = {LARGE_MODULE ? chip_addr_reg[11] : 1'b0, chip_addr_reg[9:0]};
  sequence load_s;
    mrs_hit;
  endsequence
  sequence read_s;
    rd && bl_ok && cl_ok;
  endsequence
  // ==============================
  // properties
  a_cmd_one_clock: assert property (!$past(rst) |->
    {cc, chip_ba_reg, chip_addr_reg} == $past({cs_n, ras_n, cas_n, we_n, ba, addr}))
    else $error("command stage not one clock");
  a_mode_load_word: assert property (load_s |=>
    operating_mode_word_reg == $past(chip_addr_reg)) else $error("mode word not loaded");
  a_dll_pulse_cause: assert property (dll_reset_pulse_reg == $past(dll_hit))
    else $error("dll reset pulse wrong");
  a_bit8_self_clear: assert property (operating_mode_word_reg[8] && !mrs_hit
    |=> !operating_mode_word_reg[8]) else $error("bit 8 did not clear");
  a_word_holds: assert property (!mrs_hit |=>
    $stable({operating_mode_word_reg[12:9], operating_mode_word_reg[7:0]}))
    else $error("mode word changed without load");
  a_burst_start_col: assert property (rw_hit |=> burst_active_reg &&
    burst_col_reg == $past(start_col) && burst_is_read_reg == $past(rd))
    else $error("burst start wrong");
  a_read_latency: assert property (read_s |-> ##3 read_first_data_reg)
    else $error("first read data late");
  a_half_late_flag: assert property (!$past(rst) |->
    read_half_late_reg == $past(slow)) else $error("half clock flag wrong");
endmodule
bind ddrms_top ddrms_top_properties #(.LARGE_MODULE(LARGE_MODULE)) chk_u (
  .clk(clk), .rst(rst), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .ba(ba),
  .addr(addr), .chip_cs_n_reg(chip_cs_n_reg), .chip_ras_n_reg(chip_ras_n_reg),
  .chip_cas_n_reg(chip_cas_n_reg), .chip_we_n_reg(chip_we_n_reg), .chip_ba_reg(chip_ba_reg),
  .chip_addr_reg(chip_addr_reg), .operating_mode_word_reg(operating_mode_word_reg),
  .dll_reset_pulse_reg(dll_reset_pulse_reg), .burst_active_reg(burst_active_reg),
  .burst_is_read_reg(burst_is_read_reg), .burst_col_reg(burst_col_reg),
  .read_first_data_reg(read_first_data_reg), .read_half_late_reg(read_half_late_reg));

// [test/test_ddrms_top.sv]
// bench for the ddr module mode and burst setup block
`include "ddrms_defines.vh"
module test_ddrms_top;
  timeunit 1ns;
  timeprecision 1ps;
  // ==============================
  // stimulus and observed nets
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [3:0] cmd = 4'hf;
  logic [1:0] ba = 2'h0;
  logic [12:0] addr = 13'h0000;
  logic [2:0] straps = 3'h5;
  logic [7:0] rx;
  logic ack;
  wire scl, sda, so, oe_n, c_cs, c_ras, c_cas, c_we, dll, act, isrd, first, hl;
  wire [1:0] c_ba;
  wire [12:0] c_addr, word;
  wire [10:0] col;
  int error_cnt = 0;
  int n_checks = 0;
  int cyc = 0;
  ddrms_top dut_u (.clk(clk), .rst(rst), .cs_n(cmd[3]), .ras_n(cmd[2]), .cas_n(cmd[1]),
    .we_n(cmd[0]), .ba(ba), .addr(addr), .chip_cs_n_reg(c_cs), .chip_ras_n_reg(c_ras),
    .chip_cas_n_reg(c_cas), .chip_we_n_reg(c_we), .chip_ba_reg(c_ba), .chip_addr_reg(c_addr),
    .operating_mode_word_reg(word), .dll_reset_pulse_reg(dll), .burst_active_reg(act),
    .burst_is_read_reg(isrd), .burst_col_reg(col), .read_first_data_reg(first),
    .read_half_late_reg(hl), .strap_address_select(straps), .scl_i(scl), .sda_i(sda),
    .sda_o(so), .sda_oe_n_reg(oe_n));
  ddrms_i2c_host host_u (.clk(clk), .sda_oe_n(oe_n), .scl(scl), .sda(sda));
  // 100 mhz, inside the range allowed at either latency
  initial begin
    forever #5 clk = ~clk;
  end
  // hang guard: the whole run needs well under this many cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 30000) begin
      error_cnt++;
      end_of_test();
    end
  end
  task automatic check(input logic [19:0] got, input logic [19:0] exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic end_of_test();
    $display("checks=%0d errors=%0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // one command for one clock, then nop; returns when the chips see it
  task automatic issue(input logic [3:0] c, input logic [1:0] b, input logic [12:0] a);
    @(negedge clk);
    cmd = c;
    ba = b;
    addr = a;
    @(negedge clk);
    cmd = 4'hf;
  endtask
  // ==============================
  // test sequence
  initial begin
    int len;
    int s;
    logic [12:0] e;
    repeat (6) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    @(negedge clk);
    check({oe_n, c_cs, act, so, word}, {4'hc, `DDRMS_MODE_RESET});
    // dll reset load, then a load aimed at another bank
    issue(`DDRMS_CMD_MRS, 2'h0, 13'h0162);
    check({c_cs, c_ras, c_cas, c_we, c_ba, c_addr}, {6'h00, 13'h0162});
    @(negedge clk);
    check({dll, word}, {1'b1, 13'h0162});
    @(negedge clk);
    check({dll, hl, word}, {2'h1, 13'h0062});
    issue(`DDRMS_CMD_MRS, 2'h1, 13'h0033);
    repeat (2) @(negedge clk);
    check(word, 13'h0062);
    // every length and order, normal mode loads only, start column near block top
    for (int bl = 1; bl <= 3; bl++) begin
      for (int bt = 0; bt <= 1; bt++) begin
        issue(`DDRMS_CMD_MRS, 2'h0, {6'h00, `DDRMS_CL_CODE_2, bt[0], bl[2:0]});
        len = 1 << bl;
        s = 'h2ad & (len - 1);
        issue(bt ? `DDRMS_CMD_READ : `DDRMS_CMD_WRITE, 2'h1, 13'h02ad);
        @(negedge clk);
        for (int k = 0; k < len; k++) begin
          e = ('h2ad & ~(len - 1)) | (((bt != 0) ? (s ^ k) : (s + k)) & (len - 1));
          check({isrd, act, first, col}, {bt[0], 1'b1, bt == 1 && k == 2, e[10:0]});
          @(negedge clk);
        end
        check({act, first}, {1'b0, bt == 1 && len == 2});
      end
    end
    // store: foreign strap address refused, then a high-half byte written and read back
    host_u.start();
    host_u.xfer({`DDRMS_DEV_TYPE, ~straps, 1'b0}, 1'b1, rx, ack);
    check(ack, 1'b1);
    host_u.stop();
    host_u.start();
    host_u.xfer({`DDRMS_DEV_TYPE, straps, 1'b0}, 1'b1, rx, ack);
    check(ack, 1'b0);
    host_u.xfer(8'h85, 1'b1, rx, ack);
    host_u.xfer(8'h3c, 1'b1, rx, ack);
    check(ack, 1'b0);
    host_u.stop();
    host_u.start();
    host_u.xfer({`DDRMS_DEV_TYPE, straps, 1'b0}, 1'b1, rx, ack);
    host_u.xfer(8'h85, 1'b1, rx, ack);
    host_u.start();
    host_u.xfer({`DDRMS_DEV_TYPE, straps, 1'b1}, 1'b1, rx, ack);
    host_u.xfer(8'hff, 1'b1, rx, ack);
    check(rx, 8'h3c);
    host_u.stop();
    end_of_test();
  end
endmodule
